// ---- verilog/fsp_defs.vh ----
`ifndef FSP_DEFS_VH
`define FSP_DEFS_VH

// register byte offsets, decoded on haddr[7:0]
`define FSP_ADDR_CTRL 8'h00
`define FSP_ADDR_BUF 8'h04
`define FSP_ADDR_RATE 8'h08
`define FSP_ADDR_STAT 8'h0c

// serial_control field positions
`define FSP_CTRL_MODE_HI 7
`define FSP_CTRL_MODE_LO 6
`define FSP_CTRL_FILTER 5
`define FSP_CTRL_REN 4
`define FSP_CTRL_TB8 3
`define FSP_CTRL_RB8 2
`define FSP_CTRL_TI 1
`define FSP_CTRL_RI 0
`define FSP_CTRL_RST 8'h00
`define FSP_RATE_DOUBLER 0

// modes
`define FSP_MODE0 2'h0
`define FSP_MODE1 2'h1
`define FSP_MODE2 2'h2
`define FSP_MODE3 2'h3

// machine cycle phases: index = 2*(state-1) + (phase-1)
`define FSP_PH_S1P1 4'h0
`define FSP_PH_S3P1 4'h4
`define FSP_PH_S5P2 4'h9
`define FSP_PH_S6P1 4'ha
`define FSP_PH_S6P2 4'hb
`define FSP_PH_LAST 4'hb

// 16x tick in mode 2: fosc/64 baud -> tick every 4 clocks, doubled every 2
`define FSP_M2_DIV_LAST 2'h3

// bit timing and shift register patterns
`define FSP_DIV_LAST 4'hf
`define FSP_SMP_FIRST 4'h7
`define FSP_SMP_LAST 4'h9
`define FSP_SMP_DONE 4'ha
`define FSP_RX0_PRESET 8'hfe
`define FSP_RX_PRESET 9'h1ff
`define FSP_TX_SENTINEL 8'h01

`endif

// ---- verilog/fsp_timing.v ----
`timescale 1ns/1ns
`include "fsp_defs.vh"

// machine cycle phase counter, 16x tick selection and tx bit divider
module fsp_timing (
  // clock and reset
  input wire i_clk,
  input wire i_reset,
  // configuration
  input wire [1:0] i_mode,
  input wire i_rate_doubler,
  input wire i_rate_tick,
  // timing outputs
  output reg [3:0] o_phase,
  output reg o_tick,
  output reg o_rollover
);

  reg [1:0] m2_cnt_ff;
  reg [3:0] div_ff;
  wire m2_tick;
  wire tick_sel;

  // mode 2 makes its own tick from the oscillator, others use the input
  assign m2_tick = i_rate_doubler ? m2_cnt_ff[0] :
                   (m2_cnt_ff == `FSP_M2_DIV_LAST);
  assign tick_sel = (i_mode == `FSP_MODE2) ? m2_tick : i_rate_tick;

  // twelve phases make one machine cycle, one bit in mode 0
  always @(posedge i_clk) begin
    if (i_reset) begin
      o_phase <= `FSP_PH_S1P1;
      m2_cnt_ff <= 2'h0;
      div_ff <= 4'h0;
      o_tick <= 1'b0;
      o_rollover <= 1'b0;
    end else begin
      o_phase <= (o_phase == `FSP_PH_LAST) ? `FSP_PH_S1P1 :
                 o_phase + 4'h1;
      m2_cnt_ff <= m2_cnt_ff + 2'h1;
      o_tick <= tick_sel;
      o_rollover <= tick_sel && (div_ff == `FSP_DIV_LAST);
      if (tick_sel) begin
        div_ff <= div_ff + 4'h1;
      end
    end
  end

endmodule

// ---- verilog/fsp_rx_bit.v ----
`timescale 1ns/1ns
`include "fsp_defs.vh"

// pin synchroniser with agreement filter and 2-of-3 bit detector
module fsp_rx_bit (
  // clock and reset
  input wire i_clk,
  input wire i_reset,
  // pin and sample strobe
  input wire i_pin,
  input wire i_sample,
  // results
  output reg o_level,
  output wire o_majority
);

  reg [2:0] sync_ff;
  reg [2:0] smp_ff;

  // a change counts only once stages two and three agree
  always @(posedge i_clk) begin
    if (i_reset) begin
      sync_ff <= 3'h7;
      o_level <= 1'b1;
      smp_ff <= 3'h7;
    end else begin
      sync_ff <= {sync_ff[1:0], i_pin};
      if (sync_ff[1] == sync_ff[2]) begin
        o_level <= sync_ff[2];
      end
      if (i_sample) begin
        smp_ff <= {smp_ff[1:0], o_level};
      end
    end
  end

  // noise rejection: value seen in at least two of three samples
  assign o_majority = (smp_ff[0] & smp_ff[1]) | (smp_ff[1] & smp_ff[2]) |
                      (smp_ff[0] & smp_ff[2]);

endmodule

// ---- verilog/fsp_serial_port.v ----
// Design decisions made here: the AHB-Lite register port and the register offsets.
`timescale 1ns/1ns
`include "fsp_defs.vh"

// Overview of operation
// R1: mode 0 shift clock low S3-S5, shift S6P2
// R2: mode 0 zeros enter left, sentinel triggers last shift
// R3: mode 0 tx done at S1P1, cycle ten
// R4: mode 0 rx arms, presets at S6P2
// R5: mode 0 rx samples S5P2, shifts S6P2
// R6: mode 0 rx final shift, done cycle ten
// R7: mode 1 frame start, eight data, stop
// R8: mode 1 rate from external tick
// R9: buffer write starts frame after rollover
// R10: start bit, then data, then shifting
// R11: mode 1 tx done at tenth rollover
// R12: falling edge resets divider, presets ones
// R13: majority of samples seven, eight, nine
// R14: nonzero start bit returns to hunting
// R15: start bit at left triggers final shift
// R16: mode 1 load only if flags allow
// R17: mode 1 always returns to hunting
// R18: modes 2, 3 add ninth bit
// R19: ninth bit loaded, stop inserted first shift
// R20: modes 2, 3 tx done eleventh rollover
// R21: modes 2, 3 load gated by ninth bit
// R22: stop bit ignored, hunt one bit later
// R23: mode 0 one bit per machine cycle
// R24: receive enable changed only by software
// R25: done flags cleared only by software
// R26: 16x tick input, mode 2 divides internally
module fsp_serial_port (
  // clock and reset
  input wire i_clk,
  input wire i_reset,
  // ahb-lite slave
  input wire i_hsel,
  input wire [31:0] i_haddr,
  input wire [1:0] i_htrans,
  input wire i_hwrite,
  input wire [2:0] i_hsize,
  input wire [31:0] i_hwdata,
  input wire i_hready,
  output reg [31:0] o_hrdata,
  output reg o_hreadyout,
  output reg o_hresp,
  // 16x rate tick for modes 1 and 3
  input wire i_rate_tick,
  // serial pins
  input wire i_rx_port_line,
  output reg o_rx_port_line,
  output reg o_rx_port_line_oe,
  output reg o_tx_port_line
);

  localparam [1:0] RX_HUNT = 2'h0;
  localparam [1:0] RX_RECV = 2'h1;
  localparam [1:0] RX_LINGER = 2'h2;

  // control and buffer state
  reg [1:0] mode_ff;
  reg filter_ff;
  reg ren_ff;
  reg tb8_ff;
  reg rb8_ff;
  reg ti_ff;
  reg ri_ff;
  reg doubler_ff;
  reg [7:0] rxbuf_ff;
  // bus data phase
  reg wr_pend_ff;
  reg [7:0] wr_addr_ff;
  // transmitter
  reg [8:0] tx_sr_ff;
  reg tx_req_ff;
  reg tx_arm_ff;
  reg tx_send_ff;
  reg tx_data_ff;
  reg tx_shifted_ff;
  reg tx_last_ff;
  // mode 0 receiver
  reg rx0_arm_ff;
  reg rx0_pre_ff;
  reg rx_act_ff;
  reg rx0_last_ff;
  reg rx0_smp_ff;
  reg [7:0] rx0_sr_ff;
  // asynchronous receiver
  reg [1:0] rx_state_ff;
  reg [3:0] rx_div_ff;
  reg [8:0] rx_sr_ff;
  reg rx_first_ff;
  reg prev_level_ff;

  wire [3:0] phase;
  wire tick;
  wire rollover;
  wire level;
  wire majority;
  wire mode0;
  wire acc;
  wire wr_ctrl;
  wire wr_buf;
  wire wr_rate;
  wire [3:0] nxt_phase;
  wire tx_sentinel;
  wire tx_fin0;
  wire tx_fin;
  wire rx_dec;
  wire rx_final;
  wire rx_accept;
  wire rx_sample;
  wire tx_busy;
  wire rx0_busy;
  wire [7:0] ctrl_byte;

  // bit order is reversed on load so the first bit on the wire is bit 0
  function [7:0] fsp_rev8;
    input [7:0] v;
    integer k;
    begin
      for (k = 0; k < 8; k = k + 1) begin
        fsp_rev8[k] = v[7 - k];
      end
    end
  endfunction

  // shift clock level for a phase: low from S3P1 through S5P2
  function fsp_sclk;
    input [3:0] ph;
    begin
      fsp_sclk = !((ph >= `FSP_PH_S3P1) && (ph < `FSP_PH_S6P1));
    end
  endfunction

  fsp_timing u_timing (
    .i_clk(i_clk),
    .i_reset(i_reset),
    .i_mode(mode_ff),
    .i_rate_doubler(doubler_ff),
    .i_rate_tick(i_rate_tick),
    .o_phase(phase),
    .o_tick(tick),
    .o_rollover(rollover)
  );

  fsp_rx_bit u_rx_bit (
    .i_clk(i_clk),
    .i_reset(i_reset),
    .i_pin(i_rx_port_line),
    .i_sample(rx_sample),
    .o_level(level),
    .o_majority(majority)
  );

  // bus decode; the write lands in the data phase with hwdata
  assign mode0 = (mode_ff == `FSP_MODE0);
  assign acc = i_hsel && i_htrans[1] && i_hready;
  assign wr_ctrl = wr_pend_ff && (wr_addr_ff == `FSP_ADDR_CTRL);
  assign wr_buf = wr_pend_ff && (wr_addr_ff == `FSP_ADDR_BUF);
  assign wr_rate = wr_pend_ff && (wr_addr_ff == `FSP_ADDR_RATE);
  assign nxt_phase = (phase == `FSP_PH_LAST) ? `FSP_PH_S1P1 :
                     phase + 4'h1;

  // transmit completion events
  assign tx_sentinel = (tx_sr_ff[8:1] == `FSP_TX_SENTINEL);
  assign tx_fin0 = mode0 && tx_last_ff && (phase == `FSP_PH_S1P1); // R3
  assign tx_fin = !mode0 && rollover && tx_data_ff && tx_shifted_ff &&
                  tx_sentinel; // R11 R20
  assign tx_busy = tx_req_ff | tx_arm_ff | tx_send_ff;
  assign rx0_busy = rx0_arm_ff | rx0_pre_ff | rx_act_ff;

  // asynchronous receive decisions, taken one tick after the last sample
  assign rx_sample = tick && (rx_state_ff == RX_RECV) &&
                     (rx_div_ff >= `FSP_SMP_FIRST) &&
                     (rx_div_ff <= `FSP_SMP_LAST); // R13
  assign rx_dec = tick && (rx_state_ff == RX_RECV) &&
                  (rx_div_ff == `FSP_SMP_DONE);
  assign rx_final = rx_dec && !rx_first_ff && !rx_sr_ff[8]; // R15
  assign rx_accept = rx_final && !ri_ff && (!filter_ff || majority); // R16 R21
  assign ctrl_byte = {mode_ff, filter_ff, ren_ff, tb8_ff, rb8_ff, ti_ff,
                      ri_ff};

  // ahb-lite slave: zero wait states, registered read data, always okay
  always @(posedge i_clk) begin
    if (i_reset) begin
      o_hrdata <= 32'h0;
      o_hreadyout <= 1'b1;
      o_hresp <= 1'b0;
      wr_pend_ff <= 1'b0;
      wr_addr_ff <= 8'h0;
    end else begin
      o_hreadyout <= 1'b1;
      o_hresp <= 1'b0;
      wr_pend_ff <= acc && i_hwrite;
      wr_addr_ff <= i_haddr[7:0];
      if (acc && !i_hwrite) begin
        case (i_haddr[7:0])
          `FSP_ADDR_CTRL: o_hrdata <= {24'h0, ctrl_byte};
          `FSP_ADDR_BUF: o_hrdata <= {24'h0, rxbuf_ff};
          `FSP_ADDR_RATE: o_hrdata <= {31'h0, doubler_ff};
          `FSP_ADDR_STAT: o_hrdata <= {28'h0, rx_act_ff,
                                       rx_state_ff != RX_HUNT,
                                       tx_data_ff, tx_busy};
          default: o_hrdata <= 32'h0;
        endcase
      end
    end
  end

  // control register; hardware sets win over a software write
  always @(posedge i_clk) begin
    if (i_reset) begin
      {mode_ff, filter_ff, ren_ff, tb8_ff, rb8_ff, ti_ff, ri_ff} <=
        `FSP_CTRL_RST;
      doubler_ff <= 1'b0;
    end else begin
      if (wr_ctrl) begin
        mode_ff <= i_hwdata[`FSP_CTRL_MODE_HI:`FSP_CTRL_MODE_LO];
        filter_ff <= i_hwdata[`FSP_CTRL_FILTER];
        ren_ff <= i_hwdata[`FSP_CTRL_REN]; // R24
        tb8_ff <= i_hwdata[`FSP_CTRL_TB8];
        rb8_ff <= i_hwdata[`FSP_CTRL_RB8];
        ti_ff <= i_hwdata[`FSP_CTRL_TI]; // R25
        ri_ff <= i_hwdata[`FSP_CTRL_RI]; // R25
      end
      if (wr_rate) begin
        doubler_ff <= i_hwdata[`FSP_RATE_DOUBLER];
      end
      if (rx_accept) begin
        rb8_ff <= majority; // R7 R18
      end
      if (tx_fin0 || tx_fin) begin
        ti_ff <= 1'b1;
      end
      if ((mode0 && rx0_last_ff && (phase == `FSP_PH_S1P1)) ||
          rx_accept) begin
        ri_ff <= 1'b1; // R6
      end
    end
  end

  // transmitter; a new buffer write restarts it from scratch
  always @(posedge i_clk) begin
    if (i_reset) begin
      tx_sr_ff <= 9'h0;
      tx_req_ff <= 1'b0;
      tx_arm_ff <= 1'b0;
      tx_send_ff <= 1'b0;
      tx_data_ff <= 1'b0;
      tx_shifted_ff <= 1'b0;
      tx_last_ff <= 1'b0;
    end else if (wr_buf) begin
      tx_sr_ff <= {(mode_ff[1] ? tb8_ff : 1'b1), i_hwdata[7:0]}; // R19
      tx_req_ff <= 1'b1; // R9
      tx_arm_ff <= 1'b0;
      tx_send_ff <= 1'b0;
      tx_data_ff <= 1'b0;
      tx_shifted_ff <= 1'b0;
      tx_last_ff <= 1'b0;
    end else if (mode0) begin
      // one idle machine cycle passes between the write and send
      if (phase == `FSP_PH_S1P1) begin
        if (tx_last_ff) begin
          tx_send_ff <= 1'b0; // R3
          tx_last_ff <= 1'b0;
        end else if (tx_arm_ff) begin
          tx_arm_ff <= 1'b0;
          tx_send_ff <= 1'b1;
        end else if (tx_req_ff) begin
          tx_req_ff <= 1'b0;
          tx_arm_ff <= 1'b1;
        end
      end
      if (tx_send_ff && !tx_last_ff && (phase == `FSP_PH_S6P2)) begin
        tx_sr_ff <= {1'b0, tx_sr_ff[8:1]}; // R1 R2 R23
        if (tx_sentinel) begin
          tx_last_ff <= 1'b1; // R2
        end
      end
    end else if (rollover) begin
      // bit times follow the divider, not the write
      if (tx_req_ff) begin
        tx_req_ff <= 1'b0;
        tx_send_ff <= 1'b1; // R9 R10
      end else if (tx_send_ff && !tx_data_ff) begin
        tx_data_ff <= 1'b1; // R10
      end else if (tx_data_ff) begin
        tx_sr_ff <= {mode_ff[1] && !tx_shifted_ff, tx_sr_ff[8:1]}; // R19
        tx_shifted_ff <= 1'b1;
        if (tx_fin) begin
          tx_send_ff <= 1'b0; // R11 R20
          tx_data_ff <= 1'b0;
        end
      end
    end
  end

  // mode 0 receiver, started by enable with the done flag clear
  always @(posedge i_clk) begin
    if (i_reset || !mode0) begin
      rx0_arm_ff <= 1'b0;
      rx0_pre_ff <= 1'b0;
      rx_act_ff <= 1'b0;
      rx0_last_ff <= 1'b0;
      rx0_smp_ff <= 1'b1;
      rx0_sr_ff <= 8'h0;
    end else begin
      if (phase == `FSP_PH_S1P1) begin
        if (rx0_last_ff) begin
          rx_act_ff <= 1'b0; // R6
          rx0_last_ff <= 1'b0;
        end else if (ren_ff && !ri_ff && !rx0_busy && !tx_busy) begin
          rx0_arm_ff <= 1'b1; // R4
        end
      end
      if (rx_act_ff && (phase == `FSP_PH_S5P2)) begin
        rx0_smp_ff <= level; // R5
      end
      if (phase == `FSP_PH_S6P2) begin
        if (rx0_arm_ff) begin
          rx0_arm_ff <= 1'b0;
          rx0_sr_ff <= `FSP_RX0_PRESET; // R4
          rx0_pre_ff <= 1'b1;
        end else if (rx_act_ff && !rx0_last_ff) begin
          rx0_sr_ff <= {rx0_sr_ff[6:0], rx0_smp_ff}; // R5 R23
          if (!rx0_sr_ff[7]) begin
            rx0_last_ff <= 1'b1; // R6
          end
        end
      end
      if (rx0_pre_ff) begin
        rx0_pre_ff <= 1'b0;
        rx_act_ff <= 1'b1; // R4
      end
    end
  end

  // asynchronous receiver with its own divider, aligned to the start edge
  always @(posedge i_clk) begin
    if (i_reset || mode0) begin
      rx_state_ff <= RX_HUNT;
      rx_div_ff <= 4'h0;
      rx_sr_ff <= `FSP_RX_PRESET;
      rx_first_ff <= 1'b0;
      prev_level_ff <= 1'b1;
    end else begin
      prev_level_ff <= level;
      case (rx_state_ff)
        RX_HUNT: begin
          if (ren_ff && prev_level_ff && !level) begin
            rx_state_ff <= RX_RECV;
            rx_div_ff <= 4'h0; // R12
            rx_sr_ff <= `FSP_RX_PRESET; // R12
            rx_first_ff <= 1'b1;
          end
        end
        RX_RECV: begin
          if (tick) begin
            rx_div_ff <= rx_div_ff + 4'h1; // R8 R26
          end
          if (rx_dec) begin
            rx_sr_ff <= {rx_sr_ff[7:0], majority};
            rx_first_ff <= 1'b0;
            if (rx_first_ff && majority) begin
              rx_state_ff <= RX_HUNT; // R14
            end else if (rx_final) begin
              rx_state_ff <= mode_ff[1] ? RX_LINGER : RX_HUNT; // R17 R22
            end
          end
        end
        RX_LINGER: begin
          // stop bit is not looked at, only waited out
          if (tick) begin
            rx_div_ff <= rx_div_ff + 4'h1;
          end
          if (tick && (rx_div_ff == `FSP_SMP_DONE)) begin
            rx_state_ff <= RX_HUNT; // R22
          end
        end
        default: begin
          rx_state_ff <= RX_HUNT;
        end
      endcase
    end
  end

  // receive buffer loads
  always @(posedge i_clk) begin
    if (i_reset) begin
      rxbuf_ff <= 8'h0;
    end else if (mode0 && rx_act_ff && !rx0_last_ff && !rx0_sr_ff[7] &&
                 (phase == `FSP_PH_S6P2)) begin
      rxbuf_ff <= fsp_rev8({rx0_sr_ff[6:0], rx0_smp_ff}); // R6
    end else if (rx_accept) begin
      rxbuf_ff <= fsp_rev8(rx_sr_ff[7:0]); // R16 R21
    end
  end

  // pins; mode 0 drives data on the rx line only while sending
  always @(posedge i_clk) begin
    if (i_reset) begin
      o_tx_port_line <= 1'b1;
      o_rx_port_line <= 1'b1;
      o_rx_port_line_oe <= 1'b0;
    end else if (mode0) begin
      o_tx_port_line <= (tx_send_ff || rx_act_ff) ?
                        fsp_sclk(nxt_phase) : 1'b1; // R1 R5
      o_rx_port_line <= tx_send_ff ? tx_sr_ff[0] : 1'b1;
      o_rx_port_line_oe <= tx_send_ff;
    end else begin
      o_tx_port_line <= tx_data_ff ? tx_sr_ff[0] : !tx_send_ff; // R7 R10
      o_rx_port_line <= 1'b1;
      o_rx_port_line_oe <= 1'b0;
    end
  end

endmodule

// ---- verification/fsp_serial_port_asserts.sv ----
`timescale 1ns/1ns
// port-level checks; mode is shadowed from bus writes
module fsp_serial_port_asserts (
  // clock and reset
  input wire i_clk,
  input wire i_reset,
  // bus
  input wire i_hsel,
  input wire [31:0] i_haddr,
  input wire [1:0] i_htrans,
  input wire i_hwrite,
  input wire [31:0] i_hwdata,
  input wire i_hready,
  // pins
  input wire i_rate_tick,
  input wire o_rx_port_line,
  input wire o_rx_port_line_oe,
  input wire o_tx_port_line
);
  reg [1:0] mode_ff;
  reg ctl_wr_ff;
  reg tx_prev_ff;
  reg [7:0] tick_cnt_ff;
  reg [7:0] oe_cnt_ff;
  default clocking cb @(posedge i_clk); endclocking
  default disable iff (i_reset);
  // mode lands at the data phase, as in the design
  always @(posedge i_clk) begin
    if (i_reset) begin
      mode_ff <= 2'h0;
      ctl_wr_ff <= 1'b0;
    end else begin
      ctl_wr_ff <= i_hsel && i_htrans[1] && i_hready && i_hwrite &&
                   i_haddr[7:0] == 8'h00;
      if (ctl_wr_ff)
        mode_ff <= i_hwdata[7:6];
    end
  end
  // ticks between line changes, clocks with the data pin driven
  always @(posedge i_clk) begin
    tx_prev_ff <= o_tx_port_line;
    tick_cnt_ff <= (o_tx_port_line != tx_prev_ff) ? 8'h00 :
                   tick_cnt_ff + {7'h0, i_rate_tick};
    oe_cnt_ff <= o_rx_port_line_oe ? oe_cnt_ff + 8'h01 : 8'h00;
  end
  AST_M0_CLK_LOW: assert property (
    mode_ff == 2'h0 && $fell(o_tx_port_line) |->
    !o_tx_port_line [*6] ##1 o_tx_port_line)
    else $error("shift clock low phase not six clocks");
  AST_M0_CLK_HIGH: assert property (
    o_rx_port_line_oe && $rose(o_tx_port_line) |-> o_tx_port_line [*6])
    else $error("shift clock high phase too short");
  AST_M0_DATA: assert property (
    o_rx_port_line_oe && $past(o_rx_port_line_oe) &&
    $changed(o_rx_port_line) |-> o_tx_port_line)
    else $error("data pin moved while shift clock low");
  AST_M0_LEN: assert property (
    $fell(o_rx_port_line_oe) |-> oe_cnt_ff == 8'd96)
    else $error("mode 0 send not eight machine cycles");
  AST_ASYNC_TICK: assert property (
    mode_ff[0] && $changed(o_tx_port_line) |-> $past(i_rate_tick) ||
    $past(i_rate_tick, 2) || $past(i_rate_tick, 3))
    else $error("serial line moved away from a tick");
  AST_BIT_TIME: assert property (
    mode_ff[0] && $rose(o_tx_port_line) |->
    tick_cnt_ff[3:0] == 4'h0 && tick_cnt_ff != 8'h00)
    else $error("low run not whole bit times");
  AST_NO_DRIVE: assert property (
    mode_ff != 2'h0 && $past(mode_ff) != 2'h0 |-> !o_rx_port_line_oe)
    else $error("data pin driven in async mode");
  AST_PIN_HIGH: assert property (
    mode_ff != 2'h0 && $past(mode_ff) != 2'h0 |-> o_rx_port_line)
    else $error("data pin not high in async mode");
endmodule
bind fsp_serial_port fsp_serial_port_asserts u_fsp_serial_port_asserts (
  .i_clk(i_clk), .i_reset(i_reset), .i_hsel(i_hsel), .i_haddr(i_haddr),
  .i_htrans(i_htrans), .i_hwrite(i_hwrite), .i_hwdata(i_hwdata),
  .i_hready(i_hready), .i_rate_tick(i_rate_tick),
  .o_rx_port_line(o_rx_port_line), .o_rx_port_line_oe(o_rx_port_line_oe),
  .o_tx_port_line(o_tx_port_line));

// ---- verification/fsp_remote_node.sv ----
`timescale 1ns/1ns
// far uart node; the line idles high as if pulled up
module fsp_remote_node #(parameter int BIT_CLKS = 64) (
  input wire i_clk,
  input wire i_en,
  input wire i_line,
  input wire [3:0] i_len,
  output logic o_line
);
  logic [10:0] rx_bits = 11'h0;
  int rx_count = 0;
  initial o_line = 1'b1;
  // bits go lsb first; a short first bit makes a false start
  task automatic send(input [10:0] bits, input int n, input int clks);
    for (int i = 0; i < n; i++) begin
      o_line <= bits[i];
      repeat (clks) @(posedge i_clk);
    end
    o_line <= 1'b1;
    repeat (BIT_CLKS) @(posedge i_clk);
  endtask
  // mid-bit capture after each falling edge
  initial forever begin
    @(negedge i_line);
    if (i_en) begin
      rx_bits = 11'h0;
      repeat (BIT_CLKS / 2) @(posedge i_clk);
      for (int i = 0; i < i_len; i++) begin
        rx_bits[i] = i_line;
        repeat (BIT_CLKS) @(posedge i_clk);
      end
      rx_count++;
    end
  end
endmodule

// ---- verification/fsp_serial_port_tb.sv ----
`timescale 1ns/1ns
// bus tasks, remote node and a mode 0 shift register stand-in
module fsp_serial_port_tb;
  logic i_clk = 1'b0;
  logic i_reset = 1'b1;
  logic hsel = 1'b0;
  logic [31:0] haddr = 32'h0;
  logic [1:0] htrans = 2'h0;
  logic hwrite = 1'b0;
  logic [31:0] hwdata = 32'h0;
  logic tick = 1'b0;
  logic [1:0] tick_div = 2'h0;
  logic [7:0] m0_sh = 8'h00;
  logic [7:0] m0_cap = 8'h00;
  logic sclk_prev = 1'b1;
  logic async_en = 1'b0;
  logic [3:0] frm_len = 4'ha;
  logic [31:0] q;
  wire [31:0] hrdata;
  wire hready, hresp, rx_out, rx_oe, tx_out, node_line;
  // pin level: design when driving, else whoever stands outside
  wire rx_pin = rx_oe ? rx_out : (async_en ? node_line : m0_sh[0]);
  int n_errors = 0;
  int cmp_count = 0;
  int cyc = 0;
  fsp_serial_port u_fsp_serial_port (.i_clk(i_clk), .i_reset(i_reset),
    .i_hsel(hsel), .i_haddr(haddr), .i_htrans(htrans), .i_hwrite(hwrite),
    .i_hsize(3'h2), .i_hwdata(hwdata), .i_hready(hready), .o_hrdata(hrdata),
    .o_hreadyout(hready), .o_hresp(hresp), .i_rate_tick(tick),
    .i_rx_port_line(rx_pin), .o_rx_port_line(rx_out),
    .o_rx_port_line_oe(rx_oe), .o_tx_port_line(tx_out));
  fsp_remote_node u_fsp_remote_node (.i_clk(i_clk), .i_en(async_en),
    .i_line(tx_out), .i_len(frm_len), .o_line(node_line));
  always #10 i_clk = ~i_clk;
  // tick every 4 clocks matches the mode 2 internal rate
  always @(posedge i_clk) begin
    tick_div <= tick_div + 2'h1;
    tick <= (tick_div == 2'h3);
    sclk_prev <= tx_out;
    // external register latches and advances on the rising shift clock
    if (!sclk_prev && tx_out && !async_en) begin
      if (rx_oe)
        m0_cap <= {rx_out, m0_cap[7:1]};
      else
        m0_sh <= m0_sh >> 1;
    end
    cyc++;
    if (cyc == 20000) begin
      n_errors++;
      $display("ERROR %0t: run hung", $time);
      tally_and_finish;
    end
  end
  task automatic check(input [31:0] got, input [31:0] exp);
    cmp_count++;
    if (got !== exp) begin
      n_errors++;
      $display("ERROR %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  // single word transfer; waits on hready, never on a fixed count
  task automatic bus(input [7:0] a, input logic w, input [31:0] d);
    hsel <= 1'b1;
    haddr <= {24'h0, a};
    hwrite <= w;
    htrans <= 2'h2;
    @(posedge i_clk);
    while (hready !== 1'b1) @(posedge i_clk);
    hsel <= 1'b0;
    htrans <= 2'h0;
    hwdata <= d;
    @(posedge i_clk);
    while (hready !== 1'b1) @(posedge i_clk);
    q = hrdata;
  endtask
  task automatic rd(input [7:0] a, input [31:0] m, input [31:0] e);
    bus(a, 1'b0, 32'h0);
    check(q & m, e);
  endtask
  task automatic tx_frame(input [7:0] d, input [10:0] e);
    int c;
    c = u_fsp_remote_node.rx_count;
    bus(8'h04, 1'b1, {24'h0, d});
    while (u_fsp_remote_node.rx_count == c) @(posedge i_clk);
    check({21'h0, u_fsp_remote_node.rx_bits}, {21'h0, e});
  endtask
  task automatic tally_and_finish;
    if (n_errors == 0 && cmp_count > 0)
      $display("NO MISMATCHES");
    else
      $display("MISMATCHES SEEN");
    $finish;
  endtask
  initial begin
    repeat (2) @(posedge i_clk);
    i_reset <= 1'b0;
    @(posedge i_clk);
    rd(8'h00, 32'hffffffff, 32'h0);
    rd(8'h10, 32'hffffffff, 32'h0);
    bus(8'h08, 1'b1, 32'h1);
    rd(8'h08, 32'hffffffff, 32'h1);
    bus(8'h08, 1'b1, 32'h0);
    // mode 0 send takes ten machine cycles
    bus(8'h04, 1'b1, 32'ha5);
    repeat (130) @(posedge i_clk);
    check({24'h0, m0_cap}, 32'ha5);
    rd(8'h00, 32'h2, 32'h2);
    m0_sh <= 8'h3c;
    bus(8'h00, 1'b1, 32'h10);
    repeat (130) @(posedge i_clk);
    rd(8'h04, 32'hff, 32'h3c);
    rd(8'h00, 32'h3, 32'h1);
    // mode 1
    async_en <= 1'b1;
    bus(8'h00, 1'b1, 32'h50);
    tx_frame(8'h5a, {2'b01, 8'h5a, 1'b0});
    rd(8'h00, 32'h2, 32'h2);
    u_fsp_remote_node.send({2'b01, 8'h96, 1'b0}, 10, 64);
    rd(8'h04, 32'hff, 32'h96);
    rd(8'h00, 32'h7, 32'h7);
    u_fsp_remote_node.send({2'b01, 8'h11, 1'b0}, 10, 64);
    rd(8'h04, 32'hff, 32'h96);
    bus(8'h00, 1'b1, 32'h70);
    u_fsp_remote_node.send({2'b00, 8'h22, 1'b0}, 10, 64);
    rd(8'h00, 32'h5, 32'h0);
    u_fsp_remote_node.send(11'h0, 1, 16);
    u_fsp_remote_node.send({2'b01, 8'h3e, 1'b0}, 10, 64);
    rd(8'h04, 32'hff, 32'h3e);
    rd(8'h00, 32'h5, 32'h5);
    // modes 3 and 2 carry the ninth bit
    frm_len <= 4'hb;
    bus(8'h00, 1'b1, 32'hc8);
    tx_frame(8'hc3, {2'b11, 8'hc3, 1'b0});
    rd(8'h00, 32'h2, 32'h2);
    bus(8'h00, 1'b1, 32'h80);
    tx_frame(8'h0f, {2'b10, 8'h0f, 1'b0});
    bus(8'h00, 1'b1, 32'hf0);
    u_fsp_remote_node.send({2'b10, 8'h44, 1'b0}, 11, 64);
    rd(8'h00, 32'h5, 32'h0);
    u_fsp_remote_node.send({2'b01, 8'h81, 1'b0}, 11, 64);
    rd(8'h04, 32'hff, 32'h81);
    rd(8'h00, 32'h5, 32'h5);
    tally_and_finish;
  end
endmodule
